// ==== src/sso_pkg.sv ====
package sso_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // bus and sizes
   localparam int SSO_DATA_W   = 32;
   localparam int SSO_ADDR_W   = 8;
   localparam int SSO_BE_W     = 4;
   localparam int SSO_NUM_DO   = 6;
   localparam int SSO_FUNC_W   = 4;
   localparam int SSO_NUM_FUNC = 11;
   localparam int SSO_MODE_W   = 3;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0] SSO_REG_CTRL     = 8'h00;
   localparam logic [7:0] SSO_REG_ZERO_THR = 8'h04;
   localparam logic [7:0] SSO_REG_TGT_THR  = 8'h08;
   localparam logic [7:0] SSO_REG_POS_WIN  = 8'h0c;
   localparam logic [7:0] SSO_REG_VMATCH   = 8'h10;
   localparam logic [7:0] SSO_REG_OVL_THR  = 8'h14;
   localparam logic [7:0] SSO_REG_DO_MAP   = 8'h18;
   localparam logic [7:0] SSO_REG_STATUS   = 8'h1c;
   localparam logic [7:0] SSO_REG_DO_STATE = 8'h20;
   localparam logic [7:0] SSO_REG_SPEED    = 8'h24;
   localparam logic [7:0] SSO_REG_OVL_LVL  = 8'h28;
   localparam logic [7:0] SSO_REG_EVENT    = 8'h2c;

   ////////////////////////////////////////////////////////////////////////////
   // field positions and reset values
   localparam int SSO_CTRL_MODE_LSB = 0;
   localparam int SSO_EVT_FAULT     = 0;
   localparam int SSO_EVT_WARN      = 1;
   localparam int SSO_EVT_OVL       = 2;
   localparam int SSO_EVT_W         = 3;

   localparam logic [SSO_MODE_W-1:0] SSO_RST_MODE     = 3'h0;
   localparam logic [31:0]           SSO_RST_ZERO_THR = 32'h0000000a;
   localparam logic [31:0]           SSO_RST_TGT_THR  = 32'h000000c8;
   localparam logic [31:0]           SSO_RST_POS_WIN  = 32'h00000064;
   localparam logic [31:0]           SSO_RST_VMATCH   = 32'h0000000a;
   localparam logic [31:0]           SSO_RST_OVL_THR  = 32'h00000064;
   localparam logic                  SSO_WAIT_IDLE    = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // operation modes, one-hot
   typedef enum logic [7:0] {
      SSO_MODE_PULSE_POSITION          = 8'h01,
      SSO_MODE_VELOCITY                = 8'h02,
      SSO_MODE_FORCE                   = 8'h04,
      SSO_MODE_VELOCITY_ZERO_CMD       = 8'h08,
      SSO_MODE_FORCE_ZERO_CMD          = 8'h10,
      SSO_MODE_POSITION_VELOCITY_SWITCH = 8'h20,
      SSO_MODE_POSITION_FORCE_SWITCH   = 8'h40,
      SSO_MODE_VELOCITY_FORCE_SWITCH   = 8'h80
   } sso_mode_t;

   localparam logic [7:0] SSO_POS_MODES   = 8'h61;
   localparam logic [7:0] SSO_FORCE_MODES = 8'h14;
   localparam logic [7:0] SSO_VEL_MODES   = 8'h0a;
   localparam logic [7:0] SSO_TGT_DEFAULT = 8'h8a;

   ////////////////////////////////////////////////////////////////////////////
   // output functions; code is also the bit position in the status register
   typedef enum logic [SSO_FUNC_W-1:0] {
      SSO_FN_NONE     = 4'h0,
      SSO_FN_READY    = 4'h1,
      SSO_FN_ACTIVE   = 4'h2,
      SSO_FN_ZERO     = 4'h3,
      SSO_FN_TARGET   = 4'h4,
      SSO_FN_POSREACH = 4'h5,
      SSO_FN_TQLIMIT  = 4'h6,
      SSO_FN_FAULT    = 4'h7,
      SSO_FN_WARN     = 4'h8,
      SSO_FN_OVERLOAD = 4'h9,
      SSO_FN_VMATCH   = 4'ha,
      SSO_FN_DEFAULT  = 4'hf
   } sso_dofunc_t;

   function automatic sso_mode_t sso_mode_decode(input logic [SSO_MODE_W-1:0] idx);
      case (idx)
         3'h0:    return SSO_MODE_PULSE_POSITION;
         3'h1:    return SSO_MODE_VELOCITY;
         3'h2:    return SSO_MODE_FORCE;
         3'h3:    return SSO_MODE_VELOCITY_ZERO_CMD;
         3'h4:    return SSO_MODE_FORCE_ZERO_CMD;
         3'h5:    return SSO_MODE_POSITION_VELOCITY_SWITCH;
         3'h6:    return SSO_MODE_POSITION_FORCE_SWITCH;
         3'h7:    return SSO_MODE_VELOCITY_FORCE_SWITCH;
         default: return SSO_MODE_PULSE_POSITION;
      endcase
   endfunction

   function automatic logic [32:0] sso_abs33(input logic signed [32:0] v);
      return v[32] ? 33'(-v) : 33'(v);
   endfunction

   function automatic logic [31:0] sso_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [SSO_BE_W-1:0] be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < SSO_BE_W; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic sso_dofunc_t sso_default_func(input sso_mode_t mode, input int idx);
      case (idx)
         0:       return SSO_FN_READY;
         1:       return SSO_FN_ZERO;
         2:       return ((8'(mode) & SSO_TGT_DEFAULT) != 8'h00) ? SSO_FN_TARGET : SSO_FN_NONE;
         3:       return ((8'(mode) & SSO_POS_MODES) != 8'h00) ? SSO_FN_POSREACH : SSO_FN_NONE;
         4:       return SSO_FN_FAULT;
         default: return SSO_FN_NONE;
      endcase
   endfunction

endpackage

// ==== src/sso_flag_if.sv ====
`timescale 1ns/1ps
interface sso_flag_if
   import sso_pkg::*;
#(
   parameter int NUM_DO = SSO_NUM_DO
);
   logic [SSO_NUM_FUNC-1:0]      flags;
   sso_mode_t                    mode;
   logic [NUM_DO*SSO_FUNC_W-1:0] doMap;
   logic [NUM_DO-1:0]            doLevel;

   modport status (output flags, output mode, output doMap, input doLevel);
   modport mapper (input flags, input mode, input doMap, output doLevel);
endinterface

// ==== src/sso_do_map.sv ====
`timescale 1ns/1ps
module sso_do_map
   import sso_pkg::*;
#(
   parameter int NUM_DO = SSO_NUM_DO
)(
   input wire logic   sys_clk,
   input wire logic   rst,
   sso_flag_if.mapper bus
);

   logic [NUM_DO-1:0] doLevel_ff;
   logic [NUM_DO-1:0] nxt_doLevel;

   ////////////////////////////////////////////////////////////////////////////
   // per-terminal function select; all-ones code falls back to the mode default
   for (genvar i = 0; i < NUM_DO; i++) begin : g_term
      sso_dofunc_t sel;
      always_comb begin
         sel = sso_dofunc_t'(bus.doMap[i*SSO_FUNC_W +: SSO_FUNC_W]);
         if (sel == SSO_FN_DEFAULT) begin
            sel = sso_default_func(bus.mode, i);
         end
         nxt_doLevel[i] = (int'(sel) < SSO_NUM_FUNC) ? bus.flags[sel] : 1'b0;
      end
   end

   // second register stage keeps terminal pins glitch free across remaps
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         doLevel_ff <= '0;
      end else begin
         doLevel_ff <= nxt_doLevel;
      end
   end

   assign bus.doLevel = doLevel_ff;

endmodule

// ==== src/sso_status_top.sv ====
// Function
// - drive ready is high when powered and no fault exists in the control or motor power circuit; the code also holds it low on otherFault.
// - servo active is high only while servo enable is on and the servo loop runs without fault.
// - zero velocity is high whenever measured speed magnitude is below its threshold, in every mode.
// - target velocity is high whenever actual speed magnitude exceeds its threshold.
// - position reached is high in position modes when position error magnitude is below the window.
// - torque limiting is high while torque is limited, except in the force and force zero-command modes.
// - fault is high on any alarm other than limits, emergency stop, communication error and undervoltage.
// - warning is high while a limit, emergency stop, communication error or undervoltage is present.
// - overload caution is high once the overload level reaches its threshold.
// - velocity match is high in velocity modes when command minus feedback is below its threshold.
// - which function drives each output terminal is set by software; unmapped functions need a remap.
// - the default terminal functions depend on the selected operation mode.
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module sso_status_top
   import sso_pkg::*;
#(
   parameter int NUM_DO = SSO_NUM_DO
)(
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   input  wire logic [SSO_ADDR_W-1:0]  avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [SSO_DATA_W-1:0]  avs_writedata,
   input  wire logic [SSO_BE_W-1:0]    avs_byteenable,
   output logic      [SSO_DATA_W-1:0]  avs_readdata,
   output logic                        avs_waitrequest,
   input  wire logic                   powerGood,
   input  wire logic                   ctrlCircuitFault,
   input  wire logic                   powerCircuitFault,
   input  wire logic                   otherFault,
   input  wire logic                   fwdLimit,
   input  wire logic                   revLimit,
   input  wire logic                   emergencyStop,
   input  wire logic                   commError,
   input  wire logic                   underVoltage,
   input  wire logic                   servoEnableInput,
   input  wire logic                   servoLoopOk,
   input  wire logic                   torqueLimitActive,
   input  wire logic signed [31:0]     measSpeed,
   input  wire logic signed [31:0]     cmdSpeed,
   input  wire logic signed [31:0]     posError,
   input  wire logic [31:0]            overloadLevel,
   output logic                        driveReadyOut,
   output logic                        servoActiveFlag,
   output logic                        zeroVelocityOut,
   output logic                        targetVelocityOut,
   output logic                        positionReachedOut,
   output logic                        torqueLimitingOut,
   output logic                        faultOut,
   output logic                        warningOut,
   output logic                        overloadCautionOut,
   output logic                        velocityMatchOut,
   output logic      [NUM_DO-1:0]      doTerminal
);

   localparam int MAP_W = NUM_DO * SSO_FUNC_W;

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers
   logic [SSO_MODE_W-1:0] modeIdx_ff;
   logic [SSO_MODE_W-1:0] nxt_modeIdx;
   logic [31:0]           zeroThr_ff;
   logic [31:0]           nxt_zeroThr;
   logic [31:0]           tgtThr_ff;
   logic [31:0]           nxt_tgtThr;
   logic [31:0]           posWin_ff;
   logic [31:0]           nxt_posWin;
   logic [31:0]           vmatchThr_ff;
   logic [31:0]           nxt_vmatchThr;
   logic [31:0]           ovlThr_ff;
   logic [31:0]           nxt_ovlThr;
   logic [MAP_W-1:0]      doMap_ff;
   logic [MAP_W-1:0]      nxt_doMap;
   logic [31:0]           merged;
   logic                  wrAccept;
   sso_mode_t             modeOh;

   assign wrAccept = avs_write & ~avs_waitrequest;
   assign modeOh   = sso_mode_decode(modeIdx_ff);

   always_comb begin
      nxt_modeIdx   = modeIdx_ff;
      nxt_zeroThr   = zeroThr_ff;
      nxt_tgtThr    = tgtThr_ff;
      nxt_posWin    = posWin_ff;
      nxt_vmatchThr = vmatchThr_ff;
      nxt_ovlThr    = ovlThr_ff;
      nxt_doMap     = doMap_ff;
      merged        = '0;
      if (wrAccept) begin
         case (avs_address)
            SSO_REG_CTRL: begin
               merged      = sso_merge({29'h0, modeIdx_ff}, avs_writedata, avs_byteenable);
               nxt_modeIdx = merged[SSO_CTRL_MODE_LSB +: SSO_MODE_W];
            end
            SSO_REG_ZERO_THR: nxt_zeroThr   = sso_merge(zeroThr_ff, avs_writedata, avs_byteenable);
            SSO_REG_TGT_THR:  nxt_tgtThr    = sso_merge(tgtThr_ff, avs_writedata, avs_byteenable);
            SSO_REG_POS_WIN:  nxt_posWin    = sso_merge(posWin_ff, avs_writedata, avs_byteenable);
            SSO_REG_VMATCH:   nxt_vmatchThr = sso_merge(vmatchThr_ff, avs_writedata, avs_byteenable);
            SSO_REG_OVL_THR:  nxt_ovlThr    = sso_merge(ovlThr_ff, avs_writedata, avs_byteenable);
            SSO_REG_DO_MAP: begin
               merged    = sso_merge(32'(doMap_ff), avs_writedata, avs_byteenable);
               nxt_doMap = merged[MAP_W-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         modeIdx_ff   <= SSO_RST_MODE;
         zeroThr_ff   <= SSO_RST_ZERO_THR;
         tgtThr_ff    <= SSO_RST_TGT_THR;
         posWin_ff    <= SSO_RST_POS_WIN;
         vmatchThr_ff <= SSO_RST_VMATCH;
         ovlThr_ff    <= SSO_RST_OVL_THR;
         doMap_ff     <= {NUM_DO{SSO_FN_DEFAULT}};
      end else begin
         modeIdx_ff   <= nxt_modeIdx;
         zeroThr_ff   <= nxt_zeroThr;
         tgtThr_ff    <= nxt_tgtThr;
         posWin_ff    <= nxt_posWin;
         vmatchThr_ff <= nxt_vmatchThr;
         ovlThr_ff    <= nxt_ovlThr;
         doMap_ff     <= nxt_doMap;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status flags, one evaluation per clock
   logic [SSO_NUM_FUNC-1:0] flags_ff;
   logic [SSO_NUM_FUNC-1:0] nxt_flags;
   logic [32:0]             speedMag;
   logic [32:0]             posErrMag;
   logic [32:0]             speedDiffMag;
   logic                    faultAny;
   logic                    warnAny;

   always_comb begin
      speedMag     = sso_abs33({measSpeed[31], measSpeed});
      posErrMag    = sso_abs33({posError[31], posError});
      // 33 bits so a full-scale command against opposite feedback cannot wrap
      speedDiffMag = sso_abs33(33'({cmdSpeed[31], cmdSpeed} - {measSpeed[31], measSpeed}));
      faultAny     = ctrlCircuitFault | powerCircuitFault | otherFault;
      warnAny      = fwdLimit | revLimit | emergencyStop | commError | underVoltage;
      nxt_flags    = '0;
      nxt_flags[SSO_FN_READY]    = powerGood & ~faultAny;
      nxt_flags[SSO_FN_ACTIVE]   = servoEnableInput & servoLoopOk & powerGood & ~faultAny;
      nxt_flags[SSO_FN_ZERO]     = speedMag < {1'b0, zeroThr_ff};
      nxt_flags[SSO_FN_TARGET]   = speedMag > {1'b0, tgtThr_ff};
      nxt_flags[SSO_FN_POSREACH] = ((8'(modeOh) & SSO_POS_MODES) != 8'h00) &
                                   (posErrMag < {1'b0, posWin_ff});
      nxt_flags[SSO_FN_TQLIMIT]  = ((8'(modeOh) & SSO_FORCE_MODES) == 8'h00) & torqueLimitActive;
      nxt_flags[SSO_FN_FAULT]    = faultAny;
      nxt_flags[SSO_FN_WARN]     = warnAny;
      nxt_flags[SSO_FN_OVERLOAD] = overloadLevel >= ovlThr_ff;
      nxt_flags[SSO_FN_VMATCH]   = ((8'(modeOh) & SSO_VEL_MODES) != 8'h00) &
                                   (speedDiffMag < {1'b0, vmatchThr_ff});
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         flags_ff <= '0;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky rising-edge events, write one to clear; a new edge beats the clear
   logic [SSO_EVT_W-1:0] event_ff;
   logic [SSO_EVT_W-1:0] nxt_event;
   logic [SSO_EVT_W-1:0] evtLevel;
   logic [SSO_EVT_W-1:0] evtPrev_ff;
   logic [SSO_EVT_W-1:0] evtRise;
   logic [SSO_EVT_W-1:0] evtClear;

   always_comb begin
      evtLevel = {flags_ff[SSO_FN_OVERLOAD], flags_ff[SSO_FN_WARN], flags_ff[SSO_FN_FAULT]};
      evtRise  = evtLevel & ~evtPrev_ff;
      evtClear = '0;
      if (wrAccept && (avs_address == SSO_REG_EVENT) && avs_byteenable[0]) begin
         evtClear = avs_writedata[SSO_EVT_W-1:0];
      end
      nxt_event = (event_ff & ~evtClear) | evtRise;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         event_ff   <= '0;
         evtPrev_ff <= '0;
      end else begin
         event_ff   <= nxt_event;
         evtPrev_ff <= evtLevel;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // terminal mapping stage
   sso_flag_if #(.NUM_DO(NUM_DO)) flagBus ();

   assign flagBus.flags = flags_ff;
   assign flagBus.mode  = modeOh;
   assign flagBus.doMap = doMap_ff;

   sso_do_map #(
      .NUM_DO (NUM_DO)
   ) u_do_map (
      .sys_clk (sys_clk),
      .rst     (rst),
      .bus     (flagBus)
   );

   ////////////////////////////////////////////////////////////////////////////
   // avalon slave: every access is answered on its second cycle
   logic                  waitReq_ff;
   logic                  nxt_waitReq;
   logic [SSO_DATA_W-1:0] rdata_ff;
   logic [SSO_DATA_W-1:0] nxt_rdata;

   always_comb begin
      nxt_waitReq = ~((avs_read | avs_write) & waitReq_ff);
      nxt_rdata   = rdata_ff;
      if (avs_read && waitReq_ff) begin
         case (avs_address)
            SSO_REG_CTRL:     nxt_rdata = {29'h0, modeIdx_ff};
            SSO_REG_ZERO_THR: nxt_rdata = zeroThr_ff;
            SSO_REG_TGT_THR:  nxt_rdata = tgtThr_ff;
            SSO_REG_POS_WIN:  nxt_rdata = posWin_ff;
            SSO_REG_VMATCH:   nxt_rdata = vmatchThr_ff;
            SSO_REG_OVL_THR:  nxt_rdata = ovlThr_ff;
            SSO_REG_DO_MAP:   nxt_rdata = 32'(doMap_ff);
            SSO_REG_STATUS:   nxt_rdata = 32'(flags_ff);
            SSO_REG_DO_STATE: nxt_rdata = 32'(flagBus.doLevel);
            SSO_REG_SPEED:    nxt_rdata = speedMag[31:0];
            SSO_REG_OVL_LVL:  nxt_rdata = overloadLevel;
            SSO_REG_EVENT:    nxt_rdata = 32'(event_ff);
            default:          nxt_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         waitReq_ff <= SSO_WAIT_IDLE;
         rdata_ff   <= '0;
      end else begin
         waitReq_ff <= nxt_waitReq;
         rdata_ff   <= nxt_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all from flip-flops
   assign avs_waitrequest    = waitReq_ff;
   assign avs_readdata       = rdata_ff;
   assign driveReadyOut      = flags_ff[SSO_FN_READY];
   assign servoActiveFlag    = flags_ff[SSO_FN_ACTIVE];
   assign zeroVelocityOut    = flags_ff[SSO_FN_ZERO];
   assign targetVelocityOut  = flags_ff[SSO_FN_TARGET];
   assign positionReachedOut = flags_ff[SSO_FN_POSREACH];
   assign torqueLimitingOut  = flags_ff[SSO_FN_TQLIMIT];
   assign faultOut           = flags_ff[SSO_FN_FAULT];
   assign warningOut         = flags_ff[SSO_FN_WARN];
   assign overloadCautionOut = flags_ff[SSO_FN_OVERLOAD];
   assign velocityMatchOut   = flags_ff[SSO_FN_VMATCH];
   assign doTerminal         = flagBus.doLevel;

endmodule

// ==== test/sso_host_model.sv ====
`timescale 1ns/1ps
module sso_host_model
   import sso_pkg::*;
(
   input wire logic                  sys_clk,
   input wire logic                  rst,
   input wire logic [SSO_NUM_DO-1:0] doTerminal,
   output logic     [SSO_NUM_DO-1:0] doSeen
);
   logic [SSO_NUM_DO-1:0] doSeen_ff;
   logic [SSO_NUM_DO-1:0] nxt_doSeen;
   // host only sees terminals, whatever software routed onto them
   always_comb begin
      nxt_doSeen = doTerminal;
   end
   always_ff @(posedge sys_clk) begin
      doSeen_ff <= rst ? '0 : nxt_doSeen;
   end
   assign doSeen = doSeen_ff;
endmodule

// ==== test/sso_status_asserts.sv ====
`timescale 1ns/1ps
module sso_status_asserts (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic powerGood,
   input wire logic ctrlCircuitFault,
   input wire logic powerCircuitFault,
   input wire logic otherFault,
   input wire logic fwdLimit,
   input wire logic revLimit,
   input wire logic emergencyStop,
   input wire logic commError,
   input wire logic underVoltage,
   input wire logic servoEnableInput,
   input wire logic servoLoopOk,
   input wire logic torqueLimitActive,
   input wire logic driveReadyOut,
   input wire logic servoActiveFlag,
   input wire logic torqueLimitingOut,
   input wire logic faultOut,
   input wire logic warningOut
);
   logic readyCond, faultCond, warnCond;
   assign faultCond = ctrlCircuitFault | powerCircuitFault | otherFault;
   assign warnCond  = fwdLimit | revLimit | emergencyStop | commError | underVoltage;
   assign readyCond = powerGood & ~faultCond;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   // flags lag inputs by one edge; skip the edge right after reset
   a_ready_level: assert property (
      !$past(rst) |-> driveReadyOut == $past(readyCond)) else $error("ready flag wrong");
   a_active_gate: assert property (
      !$past(rst) |-> servoActiveFlag == ($past(servoEnableInput) && $past(servoLoopOk) && $past(readyCond)))
      else $error("active flag wrong");
   a_torque_cause: assert property (
      torqueLimitingOut |-> $past(torqueLimitActive)) else $error("torque flag without cause");
   a_fault_class: assert property (
      !$past(rst) |-> faultOut == $past(faultCond)) else $error("fault flag wrong");
   a_warn_class: assert property (
      !$past(rst) |-> warningOut == $past(warnCond)) else $error("warning flag wrong");
   a_bus_answer: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("bus answer late");
   a_bus_release: assert property (
      !avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
   a_ready_steady: assert property (
      !$past(rst) && $past(readyCond) == readyCond |=> $stable(driveReadyOut)) else $error("ready glitch");
   c_read_done: cover property (avs_read && !avs_waitrequest);
   c_fault_seen: cover property (faultOut);
   c_warn_ready: cover property (warningOut && driveReadyOut);
endmodule
bind sso_status_top sso_status_asserts chk (.*);

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   import sso_pkg::*;
   logic                  sys_clk, rst, avs_read, avs_write, avs_waitrequest;
   logic [7:0]            avs_address;
   logic [31:0]           avs_writedata, avs_readdata, rdData, overloadLevel;
   logic [3:0]            avs_byteenable;
   logic                  powerGood, ctrlCircuitFault, powerCircuitFault, otherFault, fwdLimit, revLimit;
   logic                  emergencyStop, commError, underVoltage, servoEnableInput, servoLoopOk, torqueLimitActive;
   logic signed [31:0]    measSpeed, cmdSpeed, posError;
   logic                  driveReadyOut, servoActiveFlag, zeroVelocityOut, targetVelocityOut, positionReachedOut;
   logic                  torqueLimitingOut, faultOut, warningOut, overloadCautionOut, velocityMatchOut;
   logic [SSO_NUM_DO-1:0] doTerminal, doSeen;
   int                    failCount = 0;
   int                    numChecks = 0;
   sso_status_top #(.NUM_DO(SSO_NUM_DO)) dut (.*);
   sso_host_model host (.sys_clk(sys_clk), .rst(rst), .doTerminal(doTerminal), .doSeen(doSeen));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] expv, input string msg);
      numChecks++;
      if (seen !== expv) begin
         failCount++;
         $display("BAD %0t %s seen %h want %h", $time, msg, seen, expv);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", numChecks, failCount);
      if (failCount == 0 && numChecks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // holds the request until waitrequest is seen low
   task automatic busAccess(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      int n;
      @(posedge sys_clk);
      avs_address <= addr;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= wd;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rdData = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         check(32'h1, 32'h0, "bus timeout");
         results();
      end
   endtask
   // flags +1, terminals +2, host copy +3 edges
   task automatic settle();
      repeat (4) @(posedge sys_clk);
      #1;
   endtask
   ////////////////////////////////////////////////////////////
   task automatic testReset();
      busAccess(1'b0, SSO_REG_ZERO_THR, 32'h0);
      check(rdData, SSO_RST_ZERO_THR, "zero thr reset");
      busAccess(1'b0, SSO_REG_DO_MAP, 32'h0);
      check(rdData, 32'h00ffffff, "map reset");
      busAccess(1'b0, 8'h40, 32'h0);
      check(rdData, 32'h0, "unmapped read");
      $display("test reset done");
   endtask
   task automatic testClasses();
      logic [10:0] v;
      for (int i = 0; i < 11; i++) begin
         v = 11'h1 << i;
         @(posedge sys_clk);
         {servoLoopOk, powerGood} <= ~v[9:8];
         servoEnableInput <= ~v[10];
         {ctrlCircuitFault, powerCircuitFault, otherFault} <= v[2:0];
         {fwdLimit, revLimit, emergencyStop, commError, underVoltage} <= v[7:3];
         settle();
         check(driveReadyOut, !v[8] && v[2:0] == 3'h0, "ready");
         check(servoActiveFlag, v[10:8] == 3'h0 && v[2:0] == 3'h0, "active");
         check(faultOut, v[2:0] != 3'h0, "fault");
         check(warningOut, v[7:3] != 5'h0, "warning");
         check({doSeen[4], doSeen[0]}, {v[2:0] != 3'h0, !v[8] && v[2:0] == 3'h0}, "default terminals");
      end
      $display("test classes done");
   endtask
   task automatic testSpeed();
      int sp[7] = '{9, 10, -9, -10, 200, 201, -201};
      int mag;
      foreach (sp[i]) begin
         @(posedge sys_clk);
         measSpeed <= sp[i];
         mag = sp[i] < 0 ? -sp[i] : sp[i];
         settle();
         check(zeroVelocityOut, mag < 10, "zero speed");
         check(targetVelocityOut, mag > 200, "target speed");
         check(doSeen[1], mag < 10, "zero terminal");
      end
      $display("test speed done");
   endtask
   task automatic testModes();
      logic p, v;
      @(posedge sys_clk);
      {measSpeed, cmdSpeed, posError} <= {32'sd300, 32'sd309, -32'sd99};
      torqueLimitActive <= 1'b1;
      for (int m = 0; m < 8; m++) begin
         busAccess(1'b1, SSO_REG_CTRL, 32'(m));
         settle();
         p = m == 0 || m == 5 || m == 6;
         v = m == 1 || m == 3;
         check(positionReachedOut, p, "pos reached");
         check(torqueLimitingOut, m != 2 && m != 4, "torque limit");
         check(velocityMatchOut, v, "speed match");
         check(doSeen[3:2], {p, v || m == 7}, "mode terminals");
      end
      busAccess(1'b1, SSO_REG_CTRL, 32'h0);
      $display("test modes done");
   endtask
   task automatic testMapping();
      busAccess(1'b1, SSO_REG_DO_MAP, 32'h009fffff);
      for (int lvl = 99; lvl < 101; lvl++) begin
         @(posedge sys_clk);
         overloadLevel <= 32'(lvl);
         settle();
         check(overloadCautionOut, lvl >= 100, "overload");
         check(doSeen[5], lvl >= 100, "remapped terminal");
      end
      // mode 0, enable off, speed 300, error -99, torque limited, overload at threshold
      busAccess(1'b0, SSO_REG_STATUS, 32'h0);
      check(rdData, 32'h00000272, "status word");
      busAccess(1'b0, SSO_REG_DO_STATE, 32'h0);
      check(rdData, 32'h00000029, "terminal word");
      busAccess(1'b0, SSO_REG_SPEED, 32'h0);
      check(rdData, 32'd300, "speed magnitude");
      // fault and warning latched during the class test, overload just now
      busAccess(1'b0, SSO_REG_EVENT, 32'h0);
      check(rdData, 32'h7, "events latched");
      busAccess(1'b1, SSO_REG_EVENT, 32'h7);
      busAccess(1'b0, SSO_REG_EVENT, 32'h0);
      check(rdData, 32'h0, "events cleared");
      $display("test mapping done");
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      {rst, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = {3'h4, 8'h0, 32'h0, 4'hf};
      {powerGood, servoEnableInput, servoLoopOk, torqueLimitActive} = 4'he;
      {ctrlCircuitFault, powerCircuitFault, otherFault, fwdLimit, revLimit} = 5'h0;
      {emergencyStop, commError, underVoltage} = 3'h0;
      {measSpeed, cmdSpeed, posError, overloadLevel} = {32'sd0, 32'sd0, 32'sd0, 32'h0};
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      testReset();
      testClasses();
      testSpeed();
      testModes();
      testMapping();
      results();
   end
endmodule
